/* File: cmie_top.sv */
// can controller mode register, interrupt mask and status logic
// assumes a single ahb-lite master, the protocol engine on hclk,
// and that the engine acts on the mode levels driven out here
`timescale 1ns/10ps
`include "cmie_regs.svh"

module cmie_top #(
    parameter int TIMER_W = 16
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [1:0]           htrans,
    input  wire logic [31:0]          haddr,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic                 tx_pending,
    input  wire logic                 sof_pulse,
    input  wire logic                 eof_pulse,
    input  wire logic                 rx_ok,
    input  wire logic                 rx_mode_ok,
    input  wire logic                 arb_lost,
    input  wire logic [2:0]           arb_mailbox,
    input  wire logic                 timer_tick,
    input  wire logic                 timer_reset,
    input  wire cmie_pkg::cmie_evt_t  engine_evt,
    output cmie_pkg::cmie_mode_t      mode_out,
    output logic                      low_power_active,
    output logic                      overload_req,
    output logic [7:0]                mailbox_aborted,
    output logic [7:0]                mailbox_ready,
    output logic [TIMER_W-1:0]        bus_timer_value,
    output logic [TIMER_W-1:0]        frame_stamp_value,
    output logic                      irq
);
    import cmie_pkg::*;

    // ****************************************************************
    // ahb-lite slave
    // ****************************************************************
    cmie_aphase_t         ap_reg;
    cmie_aphase_t         ap_next;
    logic [31:0]          hrdata_next;
    logic                 take;
    logic                 wr_mode;
    logic                 wr_set;
    logic                 wr_clr;
    logic                 rd_status;

    // register state and next values
    cmie_mode_t           mode_reg;
    cmie_mode_t           mode_next;
    logic [31:0]          mask_reg;
    logic [31:0]          mask_next;
    logic [31:0]          status_reg;
    logic [31:0]          status_next;
    logic [31:0]          evt_set;
    cmie_lp_t             lp_reg;
    cmie_lp_t             lp_next;
    logic [TIMER_W-1:0]   timer_reg;
    logic [TIMER_W-1:0]   timer_next;
    logic [TIMER_W-1:0]   stamp_reg;
    logic [TIMER_W-1:0]   stamp_next;
    // single-cycle helpers; the next values feed output flops, the events feed status
    logic                 overload_next;
    logic [7:0]           abt_next;
    logic                 irq_next;
    logic                 lp_active_next;
    logic                 sleep_evt;
    logic                 wake_evt;
    logic                 roll_evt;
    logic                 stamp_evt;

    // address phase accepted only when the bus is ready and selected
    // hsize is not decoded; only whole aligned words are mapped
    assign take = hsel & hready & htrans[1];

    // zero wait state: read data is latched at the address phase edge
    always_comb begin
        ap_next = '0;
        hrdata_next = 32'h0000_0000;
        if (take) begin
            ap_next.wr = hwrite;
            ap_next.rd = ~hwrite;
            ap_next.addr = haddr[7:0];
        end
        if (take && !hwrite) begin
            unique case (haddr[7:0])
                `CMIE_OFS_MODE:     hrdata_next = {24'h000000, mode_reg};
                `CMIE_OFS_IRQ_MASK: hrdata_next = mask_reg;
                `CMIE_OFS_STATUS:   hrdata_next = status_reg;
                `CMIE_OFS_TIMER:    hrdata_next = 32'(timer_reg);
                `CMIE_OFS_STAMP:    hrdata_next = 32'(stamp_reg);
                default:            hrdata_next = 32'h0000_0000;
            endcase
        end
    end

    // address phase and read data registers
    // hreadyout never stalls and hresp stays okay for every access
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_reg    <= '0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= `CMIE_HREADY_RST;
            hresp     <= 1'b0;
        end else begin
            ap_reg    <= ap_next;
            hrdata    <= hrdata_next;
            hreadyout <= `CMIE_HREADY_RST;
            hresp     <= 1'b0;
        end
    end

    // write strobes act in the data phase, when hwdata stands
    assign wr_mode = ap_reg.wr & (ap_reg.addr == `CMIE_OFS_MODE);
    assign wr_set  = ap_reg.wr & (ap_reg.addr == `CMIE_OFS_IRQ_SET);
    assign wr_clr  = ap_reg.wr & (ap_reg.addr == `CMIE_OFS_IRQ_CLR);
    // status clears at the read's address edge, after its value is latched
    assign rd_status = take & ~hwrite & (haddr[7:0] == `CMIE_OFS_STATUS);

    // ****************************************************************
    // mode and mask registers
    // ****************************************************************
    // reserved mode bits and mask positions are dropped on write
    always_comb begin
        mode_next = mode_reg;
        mask_next = mask_reg;
        if (wr_mode) begin
            mode_next = cmie_mode_t'(hwdata[`CMIE_MODE_WIDTH-1:0]);
        end
        // set then clear; the same word is never written to both at once
        if (wr_set) begin
            mask_next = mask_next | (hwdata & `CMIE_IRQ_VALID);
        end
        if (wr_clr) begin
            mask_next = mask_next & ~(hwdata & `CMIE_IRQ_VALID);
        end
    end

    // ****************************************************************
    // low-power sequence
    // ****************************************************************
    // entry waits for the transmit queue to empty so no frame is cut
    // clearing the request wakes at once, even from the drain state
    always_comb begin
        lp_next = lp_reg;
        sleep_evt = 1'b0;
        wake_evt = 1'b0;
        unique case (lp_reg)
            CMIE_LP_AWAKE: begin
                if (mode_reg.low_power_request) begin
                    lp_next = CMIE_LP_DRAIN;
                end
            end
            CMIE_LP_DRAIN: begin
                if (!mode_reg.low_power_request) begin
                    lp_next = CMIE_LP_AWAKE;
                end else if (!tx_pending) begin
                    lp_next = CMIE_LP_SLEEP;
                    sleep_evt = 1'b1;
                end
            end
            CMIE_LP_SLEEP: begin
                if (!mode_reg.low_power_request) begin
                    lp_next = CMIE_LP_AWAKE;
                    wake_evt = 1'b1;
                end
            end
            // an upset code falls back to awake instead of locking up
            default: begin
                lp_next = CMIE_LP_AWAKE;
            end
        endcase
        // sleep flag taken from the next state, so it leaves a flop
        lp_active_next = (lp_next == CMIE_LP_SLEEP);
    end

    // ****************************************************************
    // bus timer and timestamp
    // ****************************************************************
    always_comb begin
        timer_next = timer_reg;
        roll_evt = 1'b0;
        stamp_next = stamp_reg;
        stamp_evt = 1'b0;
        // a disabled controller holds its count, though a timer reset still clears it
        if (timer_reset) begin
            timer_next = '0;
        end else if (timer_tick && mode_reg.controller_on) begin
            // full count: wrap with a rollover event, or hold when halted
            if (timer_reg == TIMER_W'(`CMIE_TIMER_MAX)) begin
                if (!mode_reg.timer_halt_at_max) begin
                    timer_next = '0;
                    roll_evt = 1'b1;
                end
            end else begin
                timer_next = timer_reg + TIMER_W'(1);
            end
        end
        // capture point picked by the frame-end selector
        if (mode_reg.stamp_at_frame_end ? eof_pulse : sof_pulse) begin
            stamp_next = timer_reg;
            stamp_evt = 1'b1;
        end
    end

    // ****************************************************************
    // frame side requests
    // ****************************************************************
    // requests are registered, so the engine sees one clean cycle
    always_comb begin
        overload_next = mode_reg.controller_on & mode_reg.overload_frame_gen
                   & rx_ok & rx_mode_ok;
        abt_next = 8'h00;
        if (mode_reg.controller_on && mode_reg.no_retry_on_arb_loss && arb_lost) begin
            abt_next = 8'h01 << arb_mailbox;
        end
    end

    // ****************************************************************
    // status and interrupt
    // ****************************************************************
    always_comb begin
        evt_set = 32'h0000_0000;
        // an abort counts as a mailbox event too
        evt_set[`CMIE_BIT_MB_LO +: 8]    = engine_evt.mailbox_event | abt_next;
        evt_set[`CMIE_BIT_ERR_LO +: 4]   = engine_evt.error_state;
        evt_set[`CMIE_BIT_SLEEP]         = sleep_evt;
        evt_set[`CMIE_BIT_WAKE]          = wake_evt;
        evt_set[`CMIE_BIT_ROLL]          = roll_evt;
        evt_set[`CMIE_BIT_STAMP]         = stamp_evt;
        evt_set[`CMIE_BIT_FAULT_LO +: 5] = engine_evt.fault;
        // a set in the clearing cycle survives the read
        status_next = (rd_status ? 32'h0000_0000 : status_reg) | evt_set;
        // status shares the mask layout, so one masked or-reduce drives irq
        irq_next = |(status_next & mask_next);
    end

    // ****************************************************************
    // state and output registers
    // ****************************************************************
    // one bank; every top output leaves a flop here or in the bus bank
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg         <= cmie_mode_t'(`CMIE_MODE_RST);
            mask_reg         <= `CMIE_IRQ_RST;
            status_reg       <= `CMIE_IRQ_RST;
            lp_reg           <= CMIE_LP_AWAKE;
            low_power_active <= 1'b0;
            timer_reg        <= '0;
            stamp_reg        <= '0;
            overload_req     <= 1'b0;
            mailbox_aborted  <= 8'h00;
            mailbox_ready    <= 8'h00;
            irq              <= 1'b0;
        end else begin
            mode_reg         <= mode_next;
            mask_reg         <= mask_next;
            status_reg       <= status_next;
            lp_reg           <= lp_next;
            low_power_active <= lp_active_next;
            timer_reg        <= timer_next;
            stamp_reg        <= stamp_next;
            overload_req     <= overload_next;
            mailbox_aborted <= abt_next;
            mailbox_ready   <= abt_next;
            irq             <= irq_next;
        end
    end

    // level outputs straight from their registers
    // mode_out is the register itself, so the engine sees no decode glitch
    assign mode_out          = mode_reg;
    assign bus_timer_value   = timer_reg;
    assign frame_stamp_value = stamp_reg;

endmodule // cmie_top

/* File: cmie_regs.svh */
// register map, field positions and reset values of the can mode and
// interrupt enable block; included by the top module and the testbench
`ifndef CMIE_REGS_SVH
`define CMIE_REGS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CMIE_OFS_MODE       8'h00
`define CMIE_OFS_IRQ_SET    8'h04
`define CMIE_OFS_IRQ_CLR    8'h08
`define CMIE_OFS_IRQ_MASK   8'h0C
`define CMIE_OFS_STATUS     8'h10
`define CMIE_OFS_TIMER      8'h18
`define CMIE_OFS_STAMP      8'h1C

// ****************************************************************
// field positions
// ****************************************************************
`define CMIE_MODE_WIDTH     8
`define CMIE_BIT_MB_LO      0
`define CMIE_BIT_ERR_LO     16
`define CMIE_BIT_SLEEP      20
`define CMIE_BIT_WAKE       21
`define CMIE_BIT_ROLL       22
`define CMIE_BIT_STAMP      23
`define CMIE_BIT_FAULT_LO   24

// ****************************************************************
// reset values and writable masks
// ****************************************************************
`define CMIE_MODE_RST       8'h00
`define CMIE_IRQ_RST        32'h0000_0000
`define CMIE_IRQ_VALID      32'h1FFF_00FF
`define CMIE_TIMER_MAX      16'hFFFF
`define CMIE_HREADY_RST     1'b1

`endif

/* File: cmie_pkg.sv */
// types shared by the can mode and interrupt enable block
// assumes cmie_regs.svh is on the include path
package cmie_pkg;

    // ****************************************************************
    // mode register fields, bit 7 downward
    // ****************************************************************
    typedef struct packed {
        logic no_retry_on_arb_loss;
        logic timer_halt_at_max;
        logic time_triggered;
        logic stamp_at_frame_end;
        logic overload_frame_gen;
        logic autobaud_listen;
        logic low_power_request;
        logic controller_on;
    } cmie_mode_t;

    // captured ahb address phase
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
    } cmie_aphase_t;

    // events from the protocol engine, one-cycle pulses
    typedef struct packed {
        logic [7:0] mailbox_event;
        logic [3:0] error_state;
        logic [4:0] fault;
    } cmie_evt_t;

    // low-power sequence, gray coded along the path
    typedef enum logic [1:0] {
        CMIE_LP_AWAKE = 2'b00,
        CMIE_LP_DRAIN = 2'b01,
        CMIE_LP_SLEEP = 2'b11
    } cmie_lp_t;

endpackage

/* File: cmie_top_assertions.sv */
// checker for the can mode and interrupt enable block
// assumes it is bound to cmie_top and sees its ports only
`timescale 1ns/10ps
module cmie_top_checker #(
    parameter int TIMER_W = 16
) (
    input wire logic               hclk,
    input wire logic               hresetn,
    input wire logic               tx_pending,
    input wire logic               sof_pulse,
    input wire logic               eof_pulse,
    input wire logic               rx_ok,
    input wire logic               rx_mode_ok,
    input wire logic               arb_lost,
    input wire logic [2:0]         arb_mailbox,
    input wire logic               timer_tick,
    input wire logic               timer_reset,
    input wire cmie_pkg::cmie_mode_t mode_out,
    input wire logic               low_power_active,
    input wire logic               overload_req,
    input wire logic [7:0]         mailbox_aborted,
    input wire logic [7:0]         mailbox_ready,
    input wire logic [TIMER_W-1:0] bus_timer_value,
    input wire logic [TIMER_W-1:0] frame_stamp_value
);
    import cmie_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // overload only after a qualifying reception with the option on
    a_overload_cause: assert property (overload_req |-> $past(rx_ok && rx_mode_ok
        && mode_out.overload_frame_gen && mode_out.controller_on)) else $error("stray overload");
    a_overload_sent: assert property (rx_ok && rx_mode_ok && mode_out.overload_frame_gen
        && mode_out.controller_on |=> overload_req) else $error("overload missing");
    // lost arbitration with no retry flags that mailbox alone
    a_abort_hit: assert property (arb_lost && mode_out.no_retry_on_arb_loss
        && mode_out.controller_on |=> mailbox_aborted == (8'h01 << $past(arb_mailbox))
        && mailbox_ready == mailbox_aborted) else $error("abort flags wrong");
    a_abort_cause: assert property (mailbox_aborted != 8'h00 |->
        $past(arb_lost && mode_out.no_retry_on_arb_loss)) else $error("abort without cause");
    // freeze holds the full count until a timer reset
    a_timer_hold: assert property (mode_out.timer_halt_at_max && !timer_reset
        && bus_timer_value == '1 |=> bus_timer_value == '1) else $error("timer left max");
    a_timer_wrap: assert property (mode_out.controller_on && !mode_out.timer_halt_at_max
        && timer_tick && !timer_reset && bus_timer_value == '1 |=> bus_timer_value == '0)
        else $error("timer did not wrap");
    // stamp taken at frame start or end, per the capture point bit
    a_stamp_pick: assert property (mode_out.controller_on && !timer_tick && !timer_reset
        && (mode_out.stamp_at_frame_end ? eof_pulse : sof_pulse)
        |=> frame_stamp_value == $past(bus_timer_value)) else $error("stamp not taken");
    // sleep only once the transmit queue has drained
    a_lp_drain: assert property ($rose(low_power_active) |-> !$past(tx_pending)
        && $past(mode_out.low_power_request)) else $error("sleep entered early");
endmodule // cmie_top_checker
bind cmie_top cmie_top_checker #(.TIMER_W(TIMER_W)) u_chk (.hclk, .hresetn, .tx_pending,
    .sof_pulse, .eof_pulse, .rx_ok, .rx_mode_ok, .arb_lost, .arb_mailbox, .timer_tick,
    .timer_reset, .mode_out, .low_power_active, .overload_req, .mailbox_aborted,
    .mailbox_ready, .bus_timer_value, .frame_stamp_value);

/* File: cmie_engine_model.sv */
// far-side model: protocol engine and bus events seen by the block
// assumes callers enter its tasks just after a rising hclk edge
`timescale 1ns/10ps
module cmie_engine_model (
    input  wire logic           hclk,
    output logic                tx_pending,
    output logic                sof_pulse,
    output logic                eof_pulse,
    output logic                rx_ok,
    output logic                rx_mode_ok,
    output logic                arb_lost,
    output logic [2:0]          arb_mailbox,
    output logic                timer_tick,
    output logic                timer_reset,
    output cmie_pkg::cmie_evt_t engine_evt
);
    import cmie_pkg::*;
    // idle bus, nothing queued
    initial begin
        {tx_pending, sof_pulse, eof_pulse, rx_ok, rx_mode_ok, arb_lost} = '0;
        {arb_mailbox, timer_tick, timer_reset, engine_evt} = '0;
    end
    // one-cycle event, k = {sof, eof, rx, arb, timer reset}
    task automatic pulse(input logic [4:0] k, input cmie_evt_t e, input logic [2:0] mb);
        @(posedge hclk);
        {sof_pulse, eof_pulse, rx_ok, arb_lost, timer_reset} <= k;
        engine_evt <= e;
        arb_mailbox <= mb;
        @(posedge hclk);
        {sof_pulse, eof_pulse, rx_ok, arb_lost, timer_reset} <= 5'h00;
        engine_evt <= '0;
        arb_mailbox <= ~mb; // stale index must not look valid
    endtask
    // level inputs; one driver for them, called just after an edge
    task automatic levels(input logic txp, input logic rxm);
        tx_pending <= txp;
        rx_mode_ok <= rxm;
    endtask
    // n bit-time ticks back to back
    task automatic ticks(input int n);
        @(posedge hclk);
        timer_tick <= 1'b1;
        repeat (n) @(posedge hclk);
        timer_tick <= 1'b0;
    endtask
endmodule // cmie_engine_model

/* File: can_mode_and_irq_enable_tb_top.sv */
// register-level bench for the can mode and interrupt enable block
// assumes one ahb-lite master here and the engine model on the far side
`timescale 1ns/10ps
`include "cmie_regs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module can_mode_and_irq_enable_tb_top;
    import cmie_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [1:0]  htrans;
    logic [2:0]  hsize, arb_mailbox;
    logic [31:0] haddr, hwdata, hrdata, rdv, exp_m;
    logic        tx_pending, sof_pulse, eof_pulse, rx_ok, rx_mode_ok, arb_lost;
    logic        timer_tick, timer_reset, low_power_active, overload_req, irq;
    logic [7:0]  mailbox_aborted, mailbox_ready, abt_v, rdy_v;
    logic [15:0] bus_timer_value, frame_stamp_value;
    cmie_evt_t   engine_evt, ev;
    cmie_mode_t  mode_out;
    int          n_errors = 0, cmp_count = 0, overload_cnt = 0, abt_cnt = 0;
    logic [31:0] tbl [6] = '{32'h0000_00A5, 32'h000F_0000, 32'h0030_0000,
                             32'h00C0_0000, 32'h1F00_0000, 32'hE000_FF5A};
    assign hready = hreadyout; // single slave
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    cmie_top #(.TIMER_W(16)) i_dut (.hclk, .hresetn, .hsel, .htrans, .haddr, .hwrite,
        .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .tx_pending, .sof_pulse,
        .eof_pulse, .rx_ok, .rx_mode_ok, .arb_lost, .arb_mailbox, .timer_tick, .timer_reset,
        .engine_evt, .mode_out, .low_power_active, .overload_req, .mailbox_aborted,
        .mailbox_ready, .bus_timer_value, .frame_stamp_value, .irq);
    cmie_engine_model i_eng (.hclk, .tx_pending, .sof_pulse, .eof_pulse, .rx_ok,
        .rx_mode_ok, .arb_lost, .arb_mailbox, .timer_tick, .timer_reset, .engine_evt);
    // pulses are one cycle wide, so count them as they pass
    always @(posedge hclk) begin
        if (overload_req === 1'b1) overload_cnt++;
        if (mailbox_aborted !== 8'h00) begin
            abt_cnt++;
            {abt_v, rdy_v} = {mailbox_aborted, mailbox_ready};
        end
    end
    // one single word transfer; no fixed latency is assumed
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        {htrans, haddr, hwrite} <= {2'b10, 24'h0, a, w};
        do @(posedge hclk); while (hready !== 1'b1);
        {htrans, hwdata} <= {2'b00, d};
        do @(posedge hclk); while (hready !== 1'b1);
        rdv = hrdata;
        #1; // let that edge's register updates land
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // the timer test dominates at about 66k cycles
    initial begin
        repeat (80000) @(posedge hclk);
        n_errors++;
        report_and_stop;
    end
    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata, ev} = '0;
        hsel = 1'b1;
        hsize = 3'b010;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, `CMIE_OFS_IRQ_MASK, 0);
        `CHK(rdv, 32'h0)
        `CHK({hreadyout, hresp}, 2'b10)
        bus(1, `CMIE_OFS_MODE, 32'hFFFF_FFFF);
        bus(0, `CMIE_OFS_MODE, 0);
        `CHK(rdv, 32'h0000_00FF)
        `CHK(mode_out, 8'hFF)
        bus(1, `CMIE_OFS_MODE, 32'h0000_0024);
        `CHK(mode_out, 8'h24)
        $display("test mode done");
        bus(1, `CMIE_OFS_IRQ_CLR, 32'hFFFF_FFFF);
        exp_m = 32'h0;
        foreach (tbl[i]) begin
            bus(1, `CMIE_OFS_IRQ_SET, tbl[i]);
            exp_m = exp_m | (tbl[i] & 32'h1FFF_00FF);
            bus(0, `CMIE_OFS_IRQ_MASK, 0);
            `CHK(rdv, exp_m)
        end
        bus(1, `CMIE_OFS_IRQ_CLR, 32'h0000_0081);
        bus(1, `CMIE_OFS_IRQ_SET, 32'h0);
        bus(0, `CMIE_OFS_IRQ_MASK, 0);
        `CHK(rdv, 32'h1FFF_007E)
        bus(1, `CMIE_OFS_MODE, 32'h1);
        bus(0, `CMIE_OFS_STATUS, 0);
        ev.fault = 5'h01;
        i_eng.pulse(5'h00, ev, 3'd0);
        #1 `CHK(irq, 1'b1)
        bus(0, `CMIE_OFS_STATUS, 0);
        `CHK(rdv[24], 1'b1)
        `CHK(irq, 1'b0)
        bus(1, `CMIE_OFS_IRQ_CLR, 32'h0100_0000);
        i_eng.pulse(5'h00, ev, 3'd0);
        #1 `CHK(irq, 1'b0)
        $display("test mask done");
        i_eng.levels(1'b0, 1'b1);
        bus(1, `CMIE_OFS_MODE, 32'h9);
        i_eng.pulse(5'h04, '0, 3'd0);
        bus(1, `CMIE_OFS_MODE, 32'h8);
        i_eng.pulse(5'h04, '0, 3'd0);
        bus(1, `CMIE_OFS_MODE, 32'h81);
        i_eng.pulse(5'h02, '0, 3'd5);
        bus(1, `CMIE_OFS_MODE, 32'h1);
        i_eng.pulse(5'h06, '0, 3'd2);
        repeat (2) @(posedge hclk);
        `CHK(overload_cnt, 1)
        `CHK({abt_v, rdy_v}, 16'h2020)
        `CHK(abt_cnt, 1)
        i_eng.pulse(5'h01, '0, 3'd0);
        i_eng.ticks(65535);
        #1 `CHK(bus_timer_value, 16'hFFFF)
        bus(1, `CMIE_OFS_MODE, 32'h41);
        i_eng.ticks(2);
        #1 `CHK(bus_timer_value, 16'hFFFF)
        bus(1, `CMIE_OFS_MODE, 32'h1);
        bus(0, `CMIE_OFS_STATUS, 0);
        i_eng.ticks(6);
        bus(0, `CMIE_OFS_STATUS, 0);
        `CHK(rdv[22], 1'b1)
        i_eng.pulse(5'h08, '0, 3'd0);
        #1 `CHK(frame_stamp_value, 16'h0000)
        i_eng.pulse(5'h10, '0, 3'd0);
        #1 `CHK(frame_stamp_value, 16'h0005)
        bus(1, `CMIE_OFS_MODE, 32'h11);
        i_eng.ticks(3);
        i_eng.pulse(5'h10, '0, 3'd0);
        #1 `CHK(frame_stamp_value, 16'h0005)
        i_eng.pulse(5'h08, '0, 3'd0);
        #1 `CHK(frame_stamp_value, 16'h0008)
        $display("test timer done");
        i_eng.levels(1'b1, 1'b1);
        bus(1, `CMIE_OFS_MODE, 32'h3);
        repeat (5) @(posedge hclk);
        `CHK(low_power_active, 1'b0)
        i_eng.levels(1'b0, 1'b1);
        repeat (3) @(posedge hclk);
        `CHK(low_power_active, 1'b1)
        bus(1, `CMIE_OFS_MODE, 32'h1);
        repeat (2) @(posedge hclk);
        `CHK(low_power_active, 1'b0)
        bus(0, `CMIE_OFS_STATUS, 0);
        `CHK(rdv[21:20], 2'b11)
        $display("test low power done");
        report_and_stop;
    end
endmodule // can_mode_and_irq_enable_tb_top
